/* src/valve_alert_monitor.sv */
// Threshold alert monitor: supply, temperature, travel limits and deviation.
// Assumes sensor values and register strobes come from logic on clk_sys_in.
//
// Contract
// - Supply high when pressure exceeds high point
// - Supply low when pressure below low point
// - Low point zero disables supply low
// - Each alert reported only when enabled
// - Temperature high when above high point
// - Temperature low when below low point
// - Deviation is absolute target minus travel
// - Deviation alert after persisting beyond time
// - Deviation time counted in seconds
// - Deviation alert clears past point minus deadband
// - Travel alerts independent of control mode
// - High-high sets above its point
// - High-high clears below point minus deadband
// - Low-low sets below its point
// - Low-low clears above point plus deadband
// - High sets above point, clears below minus deadband
// - Low sets below its point
// - Low clears above point plus deadband
// - Target comes from characterization output
// - Travel taken as percent of calibrated travel
`timescale 1ns/1ps

module valve_alert_monitor
    import valve_alert_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Measured values, same clock domain
    input wire sense_s sense_in,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    // Reported alerts and tick
    output alert_s alerts_out,
    output logic tick_out
);

    // Sign extension of a stored point to the comparison width
    function automatic logic signed [17:0] sext(input logic [15:0] v);
        sext = {{2{v[15]}}, v};
    endfunction

    // Zero extension of a deadband to the comparison width
    function automatic logic signed [17:0] zext(input logic [15:0] v);
        zext = {2'b00, v};
    endfunction

    // High-side alert with clear hysteresis below point minus deadband
    function automatic logic hyst_high(input logic st, input logic signed [17:0] v,
                                       input logic signed [17:0] pt,
                                       input logic signed [17:0] db);
        if (st)
        begin
            hyst_high = !(v < pt - db);
        end
        else
        begin
            hyst_high = v > pt;
        end
    endfunction

    // Low-side alert with clear hysteresis above point plus deadband
    function automatic logic hyst_low(input logic st, input logic signed [17:0] v,
                                      input logic signed [17:0] pt,
                                      input logic signed [17:0] db);
        if (st)
        begin
            hyst_low = !(v > pt + db);
        end
        else
        begin
            hyst_low = v < pt;
        end
    endfunction

    // Reset release through two flip-flops
    logic rst_meta_r;
    logic rst_sync_n;
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    // Evaluation tick divider
    logic [31:0] div_r;
    logic [31:0] div_nxt;
    logic tick_r;
    logic tick_nxt;
    always_comb
    begin
        if (div_r >= TICK_DIV - 1)
        begin
            div_nxt = 32'h0000_0000;
            tick_nxt = 1'b1;
        end
        else
        begin
            div_nxt = div_r + 32'h0000_0001;
            tick_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            div_r <= 32'h0000_0000;
            tick_r <= 1'b0;
        end
        else
        begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    // Configuration words and read data
    logic [15:0] cfg_r [CFG_WORDS];
    logic [15:0] cfg_nxt [CFG_WORDS];
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    alert_s state_r;
    alert_s state_nxt;
    alert_s report_r;
    alert_s report_nxt;
    logic [16:0] dev_r;
    logic [16:0] dev_nxt;

    // Register writes and registered reads; unmapped reads return zero
    always_comb
    begin
        cfg_nxt = cfg_r;
        rdata_nxt = rdata_r;
        if (reg_wr_in && reg_addr_in < REG_STATUS && reg_addr_in[1:0] == 2'b00)
        begin
            if (reg_addr_in == REG_ENABLE)
            begin
                cfg_nxt[0] = {7'h00, reg_wdata_in[8:0] & ENABLE_MASK};
            end
            else
            begin
                cfg_nxt[reg_addr_in[5:2]] = reg_wdata_in[15:0];
            end
        end
        if (reg_rd_in)
        begin
            if (reg_addr_in[1:0] != 2'b00)
            begin
                rdata_nxt = 32'h0000_0000;
            end
            else if (reg_addr_in < REG_STATUS)
            begin
                rdata_nxt = {16'h0000, cfg_r[reg_addr_in[5:2]]};
            end
            else if (reg_addr_in == REG_STATUS)
            begin
                rdata_nxt = {23'h000000, report_r};
            end
            else if (reg_addr_in == REG_RAW_STATE)
            begin
                rdata_nxt = {23'h000000, state_r};
            end
            else if (reg_addr_in == REG_DEVIATION)
            begin
                rdata_nxt = {15'h0000, dev_r};
            end
            else
            begin
                rdata_nxt = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            for (int i = 0; i < CFG_WORDS; i++)
            begin
                cfg_r[i] <= CFG_RESET;
            end
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Named views of the configuration words
    alert_s enables;
    logic [15:0] supply_high_point;
    logic [15:0] supply_low_point;
    logic [15:0] temp_high_point;
    logic [15:0] temp_low_point;
    logic [15:0] deviation_point;
    logic [15:0] deviation_persist_seconds;
    logic [15:0] deviation_deadband;
    logic [15:0] travel_highhigh_point;
    logic [15:0] travel_highhigh_deadband;
    logic [15:0] travel_high_point;
    logic [15:0] travel_high_deadband;
    logic [15:0] travel_low_point;
    logic [15:0] travel_low_deadband;
    logic [15:0] travel_lowlow_point;
    logic [15:0] travel_lowlow_deadband;
    assign enables = alert_s'(cfg_r[0][8:0]);
    assign supply_high_point = cfg_r[REG_SUP_HIGH[5:2]];
    assign supply_low_point = cfg_r[REG_SUP_LOW[5:2]];
    assign temp_high_point = cfg_r[REG_TEMP_HIGH[5:2]];
    assign temp_low_point = cfg_r[REG_TEMP_LOW[5:2]];
    assign deviation_point = cfg_r[REG_DEV_POINT[5:2]];
    assign deviation_persist_seconds = cfg_r[REG_DEV_SECONDS[5:2]];
    assign deviation_deadband = cfg_r[REG_DEV_DEADBAND[5:2]];
    assign travel_highhigh_point = cfg_r[REG_HIHI_POINT[5:2]];
    assign travel_highhigh_deadband = cfg_r[REG_HIHI_DEADBAND[5:2]];
    assign travel_high_point = cfg_r[REG_HIGH_POINT[5:2]];
    assign travel_high_deadband = cfg_r[REG_HIGH_DEADBAND[5:2]];
    assign travel_low_point = cfg_r[REG_LOW_POINT[5:2]];
    assign travel_low_deadband = cfg_r[REG_LOW_DEADBAND[5:2]];
    assign travel_lowlow_point = cfg_r[REG_LOLO_POINT[5:2]];
    assign travel_lowlow_deadband = cfg_r[REG_LOLO_DEADBAND[5:2]];

    // Travel and characterized target, both in percent of calibrated travel
    logic signed [17:0] travel_pct;
    logic signed [17:0] target_pct;
    logic signed [17:0] dev_diff;
    logic [16:0] dev_mag;
    logic [ELAPSED_W-1:0] elapsed_r;
    logic [ELAPSED_W-1:0] elapsed_nxt;
    logic [ELAPSED_W-1:0] persist_limit;
    logic dev_over;
    logic signed [17:0] dev_cmp;
    assign travel_pct = sext(sense_in.travel);
    assign target_pct = sext(sense_in.target);
    assign dev_diff = target_pct - travel_pct;
    assign dev_mag = dev_diff[17] ? 17'(-dev_diff) : dev_diff[16:0];
    assign dev_cmp = signed'({1'b0, dev_mag}); // Signed so a wide deadband cannot wrap
    assign dev_over = dev_cmp > zext(deviation_point);
    assign persist_limit = ELAPSED_W'(deviation_persist_seconds) * ELAPSED_W'(TICKS_PER_SEC);

    // Alert evaluation on each tick; no control-mode input takes part
    always_comb
    begin
        state_nxt = state_r;
        elapsed_nxt = elapsed_r;
        dev_nxt = dev_r;
        if (tick_r)
        begin
            dev_nxt = dev_mag;
            state_nxt.supply_high = sense_in.supply > supply_high_point;
            state_nxt.supply_low = (supply_low_point != 16'h0000) &&
                                   (sense_in.supply < supply_low_point);
            state_nxt.temp_high = sext(sense_in.temperature) > sext(temp_high_point);
            state_nxt.temp_low = sext(sense_in.temperature) < sext(temp_low_point);
            state_nxt.travel_highhigh = hyst_high(state_r.travel_highhigh, travel_pct,
                sext(travel_highhigh_point), zext(travel_highhigh_deadband));
            state_nxt.travel_high = hyst_high(state_r.travel_high, travel_pct,
                sext(travel_high_point), zext(travel_high_deadband));
            state_nxt.travel_low = hyst_low(state_r.travel_low, travel_pct,
                sext(travel_low_point), zext(travel_low_deadband));
            state_nxt.travel_lowlow = hyst_low(state_r.travel_lowlow, travel_pct,
                sext(travel_lowlow_point), zext(travel_lowlow_deadband));
            // Persistence timer runs only while deviation stays above its point
            if (dev_over)
            begin
                if (elapsed_r != {ELAPSED_W{1'b1}})
                begin
                    elapsed_nxt = elapsed_r + 1'b1;
                end
            end
            else
            begin
                elapsed_nxt = '0;
            end
            if (state_r.deviation)
            begin
                state_nxt.deviation = !(dev_cmp <
                    zext(deviation_point) - zext(deviation_deadband));
            end
            else
            begin
                state_nxt.deviation = dev_over && (elapsed_r > persist_limit);
            end
        end
    end

    // Reported alerts are gated by their enables every cycle
    always_comb
    begin
        report_nxt = alert_s'(state_nxt & enables);
    end

    always_ff @(posedge clk_sys_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state_r <= '0;
            report_r <= '0;
            elapsed_r <= '0;
            dev_r <= 17'h00000;
        end
        else
        begin
            state_r <= state_nxt;
            report_r <= report_nxt;
            elapsed_r <= elapsed_nxt;
            dev_r <= dev_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata_out = rdata_r;
    assign alerts_out = report_r;
    assign tick_out = tick_r;

    // Checks on the alert behaviour
    default clocking chk_cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_sync_n);

    sup_high_set_a: assert property (tick_r && enables.supply_high &&
        sense_in.supply > supply_high_point |=> alerts_out.supply_high)
        else $error("supply high alert missed");

    sup_low_set_a: assert property (tick_r && enables.supply_low &&
        supply_low_point != 16'h0000 && sense_in.supply < supply_low_point
        |=> alerts_out.supply_low)
        else $error("supply low alert missed");

    sup_low_off_a: assert property (tick_r && supply_low_point == 16'h0000
        |=> !state_r.supply_low)
        else $error("supply low set with zero point");

    enable_gate_a: assert property ((alerts_out & ~$past(enables)) == 9'h000)
        else $error("disabled alert reported");

    temp_high_set_a: assert property (tick_r &&
        sext(sense_in.temperature) > sext(temp_high_point) |=> state_r.temp_high)
        else $error("temperature high alert missed");

    temp_low_set_a: assert property (tick_r &&
        sext(sense_in.temperature) < sext(temp_low_point) |=> state_r.temp_low)
        else $error("temperature low alert missed");

    dev_wait_a: assert property ($rose(state_r.deviation) |->
        $past(elapsed_r) > $past(persist_limit))
        else $error("deviation alert set too early");

    hihi_hold_a: assert property (tick_r && state_r.travel_highhigh &&
        travel_pct >= sext(travel_highhigh_point) - zext(travel_highhigh_deadband)
        |=> state_r.travel_highhigh)
        else $error("high-high alert cleared inside deadband");

    low_clear_a: assert property (tick_r && state_r.travel_low &&
        travel_pct > sext(travel_low_point) + zext(travel_low_deadband)
        |=> !state_r.travel_low)
        else $error("low alert did not clear");

    hold_between_a: assert property (!tick_r |=> $stable(state_r))
        else $error("alert state changed without tick");

endmodule // valve_alert_monitor

/* src/valve_alert_pkg.sv */
// Shared constants and carriers for the valve alert monitor.
// Assumes a single 100 MHz system clock and a plain byte-addressed register port.
package valve_alert_pkg;

    // Clock and evaluation tick timing
    localparam int unsigned CLK_FREQ_MHZ = 100;
    localparam int unsigned TICK_PERIOD_US = 1000;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_US * CLK_FREQ_MHZ;
    localparam int unsigned US_PER_SEC = 1000000;
    localparam int unsigned TICKS_PER_SEC = US_PER_SEC / TICK_PERIOD_US;

    // Bus and value widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int VAL_W = 16;
    localparam int ALERT_W = 9;
    localparam int ELAPSED_W = 32;

    // Register byte offsets; configuration words sit at offset[5:2]
    localparam logic [7:0] REG_ENABLE = 8'h00;
    localparam logic [7:0] REG_SUP_HIGH = 8'h04;
    localparam logic [7:0] REG_SUP_LOW = 8'h08;
    localparam logic [7:0] REG_TEMP_HIGH = 8'h0c;
    localparam logic [7:0] REG_TEMP_LOW = 8'h10;
    localparam logic [7:0] REG_DEV_POINT = 8'h14;
    localparam logic [7:0] REG_DEV_SECONDS = 8'h18;
    localparam logic [7:0] REG_DEV_DEADBAND = 8'h1c;
    localparam logic [7:0] REG_HIHI_POINT = 8'h20;
    localparam logic [7:0] REG_HIHI_DEADBAND = 8'h24;
    localparam logic [7:0] REG_HIGH_POINT = 8'h28;
    localparam logic [7:0] REG_HIGH_DEADBAND = 8'h2c;
    localparam logic [7:0] REG_LOW_POINT = 8'h30;
    localparam logic [7:0] REG_LOW_DEADBAND = 8'h34;
    localparam logic [7:0] REG_LOLO_POINT = 8'h38;
    localparam logic [7:0] REG_LOLO_DEADBAND = 8'h3c;
    localparam logic [7:0] REG_STATUS = 8'h40;
    localparam logic [7:0] REG_RAW_STATE = 8'h44;
    localparam logic [7:0] REG_DEVIATION = 8'h48;
    localparam int CFG_WORDS = 16;

    // Reset value and enable write mask
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [8:0] ENABLE_MASK = 9'h1ff;

    // Measured values from the sensor readout logic, travel in 0.01 percent
    typedef struct packed {
        logic [15:0] supply;
        logic signed [15:0] temperature;
        logic signed [15:0] travel;
        logic signed [15:0] target;
    } sense_s;

    // Alert bit layout, shared by enables, state and status
    typedef struct packed {
        logic deviation;
        logic travel_lowlow;
        logic travel_low;
        logic travel_high;
        logic travel_highhigh;
        logic temp_low;
        logic temp_high;
        logic supply_low;
        logic supply_high;
    } alert_s;

endpackage

/* test/fieldbus_host_model.sv */
// Host model that sets alert points over the plain register port.
// Assumes the same clock as the monitor; reads return data the cycle after the strobe.
`timescale 1ns/1ps

module fieldbus_host_model
    import valve_alert_pkg::*;
(
    // Clock
    input wire logic clk_sys_in,
    // Register port towards the monitor
    output logic [ADDR_W-1:0] reg_addr_out,
    output logic [DATA_W-1:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    input wire logic [DATA_W-1:0] reg_rdata_in
);

    // Idle bus at time zero
    initial
    begin
        reg_addr_out = 8'h00;
        reg_wdata_out = 32'h0000_0000;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
    end

    // One-cycle write; address and data are scrambled once the strobe drops
    task automatic write_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~d;
    endtask

    // One-cycle read; data taken in the following cycle only
    task automatic read_word(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_sys_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~a;
        #1;
        d = reg_rdata_in;
    endtask

endmodule // fieldbus_host_model

/* test/valve_alert_monitor_test.sv */
// Self-checking bench for the valve alert monitor.
// Assumes a short tick divider so deviation timing stays within a short run.
`timescale 1ns/1ps

module valve_alert_monitor_test;
    import valve_alert_pkg::*;

    localparam int DIV = 10;
    typedef struct {
        logic [15:0] sup;
        logic [15:0] tmp;
        logic [15:0] tvl;
        logic [8:0] en;
        logic [8:0] exp;
    } row_s;

    logic clk_sys_in;
    logic rst_n_in;
    sense_s sense;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    alert_s alerts;
    logic tick;
    logic [31:0] rd;
    int fails;
    int n_tests;

    // Travel rows run in order so hysteresis carries from row to row
    row_s rows[16] = '{
        '{16'h01f4, 16'h0019, 16'h1388, 9'h1ff, 9'h000},
        '{16'h03e9, 16'h0051, 16'h1388, 9'h1ff, 9'h005},
        '{16'h03e8, 16'h0050, 16'h1388, 9'h1ff, 9'h000},
        '{16'h00c7, 16'hfff5, 16'h1388, 9'h1ff, 9'h00a},
        '{16'h00c8, 16'hfff6, 16'h1388, 9'h1ff, 9'h000},
        '{16'h01f4, 16'h0019, 16'h2329, 9'h1ff, 9'h030},
        '{16'h01f4, 16'h0019, 16'h2261, 9'h1ff, 9'h030},
        '{16'h01f4, 16'h0019, 16'h225f, 9'h1ff, 9'h020},
        '{16'h01f4, 16'h0019, 16'h1e13, 9'h1ff, 9'h000},
        '{16'h01f4, 16'h0019, 16'h03e7, 9'h1ff, 9'h0c0},
        '{16'h01f4, 16'h0019, 16'h04af, 9'h1ff, 9'h0c0},
        '{16'h01f4, 16'h0019, 16'h04b1, 9'h1ff, 9'h040},
        '{16'h01f4, 16'h0019, 16'h08fd, 9'h1ff, 9'h000},
        '{16'h03e9, 16'h0051, 16'h03e7, 9'h000, 9'h000},
        '{16'h03e9, 16'h0051, 16'h03e7, 9'h1ff, 9'h0c5},
        '{16'h01f4, 16'h0019, 16'h1388, 9'h1ff, 9'h000}
    };
    logic [7:0] cfg_a[14] = '{REG_SUP_HIGH, REG_SUP_LOW, REG_TEMP_HIGH, REG_TEMP_LOW,
        REG_DEV_POINT, REG_DEV_SECONDS, REG_DEV_DEADBAND, REG_HIHI_POINT, REG_HIHI_DEADBAND,
        REG_HIGH_POINT, REG_HIGH_DEADBAND, REG_LOW_POINT, REG_LOW_DEADBAND, REG_LOLO_POINT};
    logic [15:0] cfg_d[14] = '{16'h03e8, 16'h00c8, 16'h0050, 16'hfff6, 16'h01f4, 16'h0001,
        16'h0064, 16'h2328, 16'h00c8, 16'h1f40, 16'h012c, 16'h07d0, 16'h012c, 16'h03e8};

    // Design and host
    valve_alert_monitor #(.TICK_DIV(DIV)) valve_alert_monitor_i (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sense_in(sense),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .alerts_out(alerts), .tick_out(tick));
    fieldbus_host_model fieldbus_host_model_i (
        .clk_sys_in(clk_sys_in), .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
        .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_rdata_in(reg_rdata));

    // Clock generator
    initial
    begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // Verdict and end of run
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Wait for n evaluation ticks, bounded, then let the result settle
    task automatic ticks(input int n);
        int cnt;
        cnt = 0;
        for (int k = 0; k < n * DIV * 2 + 4 && cnt < n; k++)
        begin
            @(posedge clk_sys_in);
            if (tick === 1'b1)
                cnt++;
        end
        if (cnt < n)
        begin
            fails++;
            close_out();
        end
        @(posedge clk_sys_in);
        #1;
    endtask

    task automatic apply(input logic [15:0] s, input logic [15:0] t, input logic [15:0] tv,
                         input logic [15:0] tg);
        @(posedge clk_sys_in);
        sense <= {s, t, tv, tg};
    endtask

    // Main sequence
    initial
    begin
        fails = 0;
        n_tests = 0;
        sense = '0;
        rst_n_in = 1'b0;
        repeat (12) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        // Register map basics
        fieldbus_host_model_i.read_word(REG_SUP_HIGH, rd);
        check(rd, 32'h0);
        fieldbus_host_model_i.write_word(REG_SUP_HIGH, 32'hffff1234);
        fieldbus_host_model_i.read_word(REG_SUP_HIGH, rd);
        check(rd, 32'h0000_1234);
        fieldbus_host_model_i.write_word(REG_ENABLE, 32'hffffffff);
        fieldbus_host_model_i.read_word(REG_ENABLE, rd);
        check(rd, 32'h0000_01ff);
        fieldbus_host_model_i.write_word(REG_STATUS, 32'h1ff);
        fieldbus_host_model_i.read_word(REG_STATUS, rd);
        check(rd, 32'h0);
        fieldbus_host_model_i.read_word(8'h4c, rd);
        check(rd, 32'h0);
        for (int i = 0; i < 14; i++)
            fieldbus_host_model_i.write_word(cfg_a[i], {16'h0, cfg_d[i]});
        fieldbus_host_model_i.write_word(REG_LOLO_DEADBAND, 32'h00c8);
        // Table of threshold cases
        foreach (rows[i])
        begin
            fieldbus_host_model_i.write_word(REG_ENABLE, {23'h0, rows[i].en});
            apply(rows[i].sup, rows[i].tmp, rows[i].tvl, rows[i].tvl);
            ticks(2);
            check({23'h0, alerts}, {23'h0, rows[i].exp});
        end
        // Zero low point disables supply low
        fieldbus_host_model_i.write_word(REG_SUP_LOW, 32'h0);
        apply(16'h0000, 16'h0019, 16'h1388, 16'h1388);
        ticks(2);
        check({23'h0, alerts}, 32'h0);
        // Deviation persistence of one second, travel above then below target
        apply(16'h01f4, 16'h0019, 16'h15e0, 16'h1388);
        ticks(1000);
        check({31'h0, alerts.deviation}, 32'h0);
        fieldbus_host_model_i.read_word(REG_DEVIATION, rd);
        check(rd, 32'h0258);
        ticks(2);
        check({31'h0, alerts.deviation}, 32'h1);
        apply(16'h01f4, 16'h0019, 16'h154a, 16'h1388);
        ticks(2);
        check({31'h0, alerts.deviation}, 32'h1);
        apply(16'h01f4, 16'h0019, 16'h150e, 16'h1388);
        ticks(2);
        check({31'h0, alerts.deviation}, 32'h0);
        apply(16'h01f4, 16'h0019, 16'h1130, 16'h1388);
        ticks(2);
        fieldbus_host_model_i.read_word(REG_DEVIATION, rd);
        check(rd, 32'h0258);
        // Mid-run reset clears a standing alert
        apply(16'h03e9, 16'h0019, 16'h1388, 16'h1388);
        ticks(2);
        check({23'h0, alerts}, 32'h001);
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        check({22'h0, tick, alerts}, 32'h0);
        @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        fieldbus_host_model_i.read_word(REG_SUP_HIGH, rd);
        check(rd, 32'h0);
        close_out();
    end

endmodule // valve_alert_monitor_test
